//--- sac_regs.vh
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// register indices; byte address is four times the index
`define SAC_IDX_MODE      16'hFF80
`define SAC_IDX_CHAN      16'hFF81
`define SAC_IDX_RES_WORD  16'hFF18
`define SAC_IDX_RES_HIGH  16'hFF1A
`define SAC_IDX_STATUS    16'hFF1B

`define SAC_MODE_RESET    8'h00
`define SAC_CHAN_RESET    8'h00
`define SAC_MODE_MASK     8'hB9
`define SAC_CHAN_MASK     8'h03

`define SAC_BIT_START     7
`define SAC_BIT_CMP_EN    0
`define SAC_FR_HI         5
`define SAC_FR_LO         3
`define SAC_CH_HI         1
`define SAC_CH_LO         0

`define SAC_RES_BITS      10
`define SAC_RES_MSB       4'h9
`define SAC_RES_TOP       10'h200
`define SAC_HIGH_LO       2

// sampling and total conversion lengths in peripheral clocks
`define SAC_SMP_000       8'h0C
`define SAC_SMP_001       8'h18
`define SAC_SMP_010       8'h30
`define SAC_SMP_011       8'h58
`define SAC_SMP_100       8'h18
`define SAC_SMP_101       8'h30
`define SAC_SMP_110       8'h60
`define SAC_SMP_111       8'hB0
`define SAC_CNV_000       8'h24
`define SAC_CNV_001       8'h30
`define SAC_CNV_010       8'h48
`define SAC_CNV_011       8'h70
`define SAC_CNV_100       8'h48
`define SAC_CNV_101       8'h60
`define SAC_CNV_110       8'h90
`define SAC_CNV_111       8'hE0

`define SAC_CLK_PERIOD_NS 10
`define SAC_CMP_SETTLE_NS 1000
`define SAC_CMP_SETTLE_CYC ((`SAC_CMP_SETTLE_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_FXP_DIV       10

`define SAC_RESP_OKAY     2'h0
`define SAC_RESP_SLVERR   2'h2

`endif

//--- sac_prescale.v
`include "sac_regs.vh"
`default_nettype none

// peripheral clock enable; clr restarts the phase so a conversion
// always starts on a whole peripheral clock
module sac_prescale #(
  parameter DIV = `SAC_FXP_DIV
) (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       clr,
  output reg        tick
);

  reg [7:0] cnt_r;
  localparam integer LAST_I = DIV - 1;
  localparam [7:0]   LAST   = LAST_I[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
      tick  <= 1'b0;
    end else if (clr) begin
      cnt_r <= 8'h00;
      tick  <= 1'b0;
    end else begin
      tick <= (cnt_r == LAST);
      if (cnt_r == LAST)
        cnt_r <= 8'h00;
      else
        cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule

`default_nettype wire

//--- sac_axil.v
`include "sac_regs.vh"
`default_nettype none

module sac_axil #(
  parameter ADDR_W = 18
) (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // write channels
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // read channels
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // core side
  output reg               reg_wr,
  output reg  [15:0]       reg_wr_idx,
  output reg  [7:0]        reg_wr_data,
  output wire [15:0]       reg_rd_idx,
  input  wire [31:0]       reg_rd_data
);

  function mapped;
    input [15:0] idx;
    begin
      mapped = (idx == `SAC_IDX_MODE) || (idx == `SAC_IDX_CHAN) ||
               (idx == `SAC_IDX_RES_WORD) || (idx == `SAC_IDX_RES_HIGH) ||
               (idx == `SAC_IDX_STATUS);
    end
  endfunction

  reg        aw_full_r;
  reg        w_full_r;
  reg [15:0] aw_idx_r;
  reg [7:0]  w_byte_r;
  reg        w_lane0_r;

  assign reg_rd_idx = s_axi_araddr[17:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SAC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SAC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      aw_idx_r      <= 16'h0000;
      w_byte_r      <= 8'h00;
      w_lane0_r     <= 1'b0;
      reg_wr        <= 1'b0;
      reg_wr_idx    <= 16'h0000;
      reg_wr_data   <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      // ready rises one cycle after reset and after each response
      if (!aw_full_r && !s_axi_bvalid && !s_axi_awready)
        s_axi_awready <= 1'b1;
      if (!w_full_r && !s_axi_bvalid && !s_axi_wready)
        s_axi_wready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r     <= 1'b1;
        aw_idx_r      <= s_axi_awaddr[17:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r     <= 1'b1;
        w_byte_r     <= s_axi_wdata[7:0];
        w_lane0_r    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_full_r && w_full_r && !s_axi_bvalid) begin
        // only byte lane 0 carries register bits; other lanes ignored
        reg_wr       <= w_lane0_r && mapped(aw_idx_r);
        reg_wr_idx   <= aw_idx_r;
        reg_wr_data  <= w_byte_r;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_idx_r) ? `SAC_RESP_OKAY
                                         : `SAC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
      end
      if (!s_axi_rvalid && !s_axi_arready)
        s_axi_arready <= 1'b1;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= mapped(reg_rd_idx) ? reg_rd_data : 32'h0000_0000;
        s_axi_rresp   <= mapped(reg_rd_idx) ? `SAC_RESP_OKAY
                                            : `SAC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- sac_controller.v
// Our own choice: the AXI4-Lite slave port.
`include "sac_regs.vh"
`default_nettype none

// Operation
// - result is resolved one bit at a time, MSB first down to LSB
// - each finished conversion loads the 16-bit word, low 10 bits, top zero
// - each finished conversion loads the byte register with the top 8 bits
// - a done interrupt is raised every time a conversion finishes
// - mode and channel registers reset to zero; written only as whole bytes on lane 0
// - mode bit 7 starts or stops conversion; bit 0 enables comparator
// - mode bits 5..3 pick sampling and total lengths from eight pairs
// - counted conversion length covers sampling plus all comparisons
// - start works with comparator off; that first result is unreliable
// - start/enable pick stopped, comparator-only waiting, or converting
// - channel bits 1..0 route input 0 to 3 to the converter
// - conversions repeat on the channel while start stays set
// - writing mode or channel mid-conversion aborts it; it restarts only if start is still set
// - trial bit stays 1 when input is at least the tap, else cleared
module sac_controller #(
  parameter FXP_DIV = `SAC_FXP_DIV
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address and data
  input  wire [17:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [17:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // analog front end
  input  wire        cmp_above,
  output reg  [1:0]  ana_sel,
  output reg         ana_sample,
  output reg         cmp_power,
  output reg  [9:0]  dac_code,
  // events
  output reg         conv_done_irq
);

  localparam [3:0] ST_STOP   = 4'h1;
  localparam [3:0] ST_WAIT   = 4'h2;
  localparam [3:0] ST_SAMPLE = 4'h4;
  localparam [3:0] ST_COMP   = 4'h8;
  localparam integer SETTLE_I = `SAC_CMP_SETTLE_CYC;
  localparam [7:0] SETTLE    = SETTLE_I[7:0];

  // sampling length per clock-select code
  function [7:0] smp_len;
    input [2:0] fr;
    begin
      case (fr)
        3'h0:    smp_len = `SAC_SMP_000;
        3'h1:    smp_len = `SAC_SMP_001;
        3'h2:    smp_len = `SAC_SMP_010;
        3'h3:    smp_len = `SAC_SMP_011;
        3'h4:    smp_len = `SAC_SMP_100;
        3'h5:    smp_len = `SAC_SMP_101;
        3'h6:    smp_len = `SAC_SMP_110;
        default: smp_len = `SAC_SMP_111;
      endcase
    end
  endfunction

  // total length, sampling included
  function [7:0] cnv_len;
    input [2:0] fr;
    begin
      case (fr)
        3'h0:    cnv_len = `SAC_CNV_000;
        3'h1:    cnv_len = `SAC_CNV_001;
        3'h2:    cnv_len = `SAC_CNV_010;
        3'h3:    cnv_len = `SAC_CNV_011;
        3'h4:    cnv_len = `SAC_CNV_100;
        3'h5:    cnv_len = `SAC_CNV_101;
        3'h6:    cnv_len = `SAC_CNV_110;
        default: cnv_len = `SAC_CNV_111;
      endcase
    end
  endfunction

  // clocks per comparison; the leftover is spent before the result lands
  function [7:0] step_len;
    input [2:0] fr;
    reg [31:0] q;
    begin
      q = (cnv_len(fr) - smp_len(fr)) / `SAC_RES_BITS;
      step_len = q[7:0];
    end
  endfunction

  // settle the trial bit and raise the next lower one
  function [9:0] resolve;
    input [9:0] v;
    input [3:0] i;
    input       keep;
    reg   [9:0] r;
    begin
      r = v;
      r[i] = keep;
      if (i != 4'h0)
        r[i - 4'h1] = 1'b1;
      resolve = r;
    end
  endfunction

  wire [15:0] reg_wr_idx;
  wire [7:0]  reg_wr_data;
  wire        reg_wr;
  wire [15:0] reg_rd_idx;
  reg  [31:0] reg_rd_data;

  reg  [7:0]  mode_r;
  reg  [7:0]  chan_r;
  reg  [3:0]  state_r;
  reg  [7:0]  cnt_r;
  reg  [7:0]  step_cnt_r;
  reg  [7:0]  smp_len_r;
  reg  [7:0]  cnv_len_r;
  reg  [7:0]  step_len_r;
  reg  [3:0]  bit_idx_r;
  reg         bits_done_r;
  reg  [9:0]  sar_r;
  reg  [9:0]  res_r;
  reg         first_suspect_r;
  reg         res_suspect_r;
  reg  [7:0]  settle_cnt_r;
  reg         cmp_meta_r;
  reg         cmp_sync_r;
  wire        tick;

  sac_axil #(
    .ADDR_W (18)
  ) u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_wr_idx    (reg_wr_idx),
    .reg_wr_data   (reg_wr_data),
    .reg_rd_idx    (reg_rd_idx),
    .reg_rd_data   (reg_rd_data)
  );

  wire mode_wr  = reg_wr && (reg_wr_idx == `SAC_IDX_MODE);
  wire chan_wr  = reg_wr && (reg_wr_idx == `SAC_IDX_CHAN);
  wire cfg_wr   = mode_wr || chan_wr;
  wire start_b  = mode_r[`SAC_BIT_START];
  wire cmp_en_b = mode_r[`SAC_BIT_CMP_EN];
  wire [2:0] fr = mode_r[`SAC_FR_HI:`SAC_FR_LO];
  wire idle_st  = (state_r == ST_STOP) || (state_r == ST_WAIT);
  wire comp_st  = (state_r == ST_COMP);
  wire last_tk  = comp_st && tick && (cnt_r + 8'h01 == cnv_len_r);
  // a config write always wins, so a launch waits one cycle after it
  wire launch   = !cfg_wr && start_b && (idle_st || last_tk);

  sac_prescale #(
    .DIV (FXP_DIV)
  ) u_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (launch),
    .tick    (tick)
  );

  // comparator output is analog-timed; resync before use
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cmp_meta_r <= cmp_above;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // comparator settling time since enable
  always @(posedge aclk) begin
    if (!aresetn)
      settle_cnt_r <= 8'h00;
    else if (!(cmp_en_b || start_b))
      settle_cnt_r <= 8'h00;
    else if (settle_cnt_r != SETTLE)
      settle_cnt_r <= settle_cnt_r + 8'h01;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r          <= `SAC_MODE_RESET;
      chan_r          <= `SAC_CHAN_RESET;
      state_r         <= ST_STOP;
      cnt_r           <= 8'h00;
      step_cnt_r      <= 8'h00;
      smp_len_r       <= 8'h00;
      cnv_len_r       <= 8'h00;
      step_len_r      <= 8'h00;
      bit_idx_r       <= 4'h0;
      bits_done_r     <= 1'b0;
      sar_r           <= 10'h000;
      res_r           <= 10'h000;
      first_suspect_r <= 1'b0;
      res_suspect_r   <= 1'b0;
    end else begin
      if (mode_wr)
        mode_r <= reg_wr_data & `SAC_MODE_MASK;
      if (chan_wr)
        chan_r <= reg_wr_data & `SAC_CHAN_MASK;
      // an aborting write in the finishing cycle leaves the result alone
      if (last_tk && !cfg_wr) begin
        res_r           <= sar_r;
        res_suspect_r   <= first_suspect_r;
        first_suspect_r <= 1'b0;
      end
      if (cfg_wr) begin
        state_r <= ST_STOP;
      end else if (launch) begin
        state_r    <= ST_SAMPLE;
        cnt_r      <= 8'h00;
        smp_len_r  <= smp_len(fr);
        cnv_len_r  <= cnv_len(fr);
        step_len_r <= step_len(fr);
        sar_r      <= 10'h000;
        if (idle_st)
          first_suspect_r <= (settle_cnt_r != SETTLE);
      end else begin
        case (state_r)
          ST_STOP, ST_WAIT: begin
            state_r <= cmp_en_b ? ST_WAIT : ST_STOP;
          end
          ST_SAMPLE: begin
            if (tick) begin
              cnt_r <= cnt_r + 8'h01;
              if (cnt_r + 8'h01 == smp_len_r) begin
                state_r     <= ST_COMP;
                sar_r       <= `SAC_RES_TOP;
                bit_idx_r   <= `SAC_RES_MSB;
                bits_done_r <= 1'b0;
                step_cnt_r  <= 8'h00;
              end
            end
          end
          ST_COMP: begin
            if (last_tk) begin
              state_r <= cmp_en_b ? ST_WAIT : ST_STOP;
            end else if (tick) begin
              cnt_r <= cnt_r + 8'h01;
              if (!bits_done_r) begin
                if (step_cnt_r + 8'h01 == step_len_r) begin
                  step_cnt_r <= 8'h00;
                  sar_r <= resolve(sar_r, bit_idx_r, cmp_sync_r);
                  if (bit_idx_r == 4'h0)
                    bits_done_r <= 1'b1;
                  else
                    bit_idx_r <= bit_idx_r - 4'h1;
                end else begin
                  step_cnt_r <= step_cnt_r + 8'h01;
                end
              end
            end
          end
          default: state_r <= ST_STOP;
        endcase
      end
    end
  end

  // front-end drive, registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      ana_sel       <= 2'h0;
      ana_sample    <= 1'b0;
      cmp_power     <= 1'b0;
      dac_code      <= 10'h000;
      conv_done_irq <= 1'b0;
    end else begin
      ana_sel       <= chan_r[`SAC_CH_HI:`SAC_CH_LO];
      ana_sample    <= (state_r == ST_SAMPLE);
      cmp_power     <= cmp_en_b || start_b;
      dac_code      <= sar_r;
      conv_done_irq <= last_tk && !cfg_wr;
    end
  end

  always @* begin
    reg_rd_data = 32'h0000_0000;
    case (reg_rd_idx)
      `SAC_IDX_MODE:     reg_rd_data[7:0] = mode_r;
      `SAC_IDX_CHAN:     reg_rd_data[7:0] = chan_r;
      `SAC_IDX_RES_WORD: reg_rd_data[9:0] = res_r;
      `SAC_IDX_RES_HIGH: reg_rd_data[7:0] = res_r[9:`SAC_HIGH_LO];
      `SAC_IDX_STATUS:   reg_rd_data[3:0] = {res_suspect_r,
                                             state_r == ST_WAIT,
                                             state_r == ST_COMP,
                                             state_r == ST_SAMPLE};
      default:           reg_rd_data = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

//--- sac_controller_properties.sv
`default_nettype none
module sac_controller_properties #(
  parameter int FXP_DIV = 10
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // converter
  input wire logic        ana_sample,
  input wire logic        cmp_power,
  input wire logic [9:0]  dac_code,
  input wire logic        conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int smp_len_r;
  // length of the current sampling window, cleared when the switch opens
  always @(posedge aclk) begin
    if (!aresetn || !ana_sample) smp_len_r <= 0;
    else smp_len_r <= smp_len_r + 1;
  end
  a_irq_one_pulse: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("done pulse longer than one cycle");
  a_dac_msb_first: assert property (
    $fell(ana_sample) && !$past(s_axi_bvalid, 2) |->
    ##[0:2] dac_code == 10'h200)
    else $error("first trial is not the top bit");
  a_sample_min: assert property (
    // a write answered two cycles earlier may have cut sampling short
    $fell(ana_sample) && !$past(s_axi_bvalid, 2) |->
    smp_len_r >= 12 * FXP_DIV - 1)
    else $error("sampling window too short");
  a_irq_after_cmp: assert property (
    conv_done_irq |-> !ana_sample && !$past(ana_sample))
    else $error("done raised during sampling");
  a_sample_power: assert property (ana_sample |-> cmp_power)
    else $error("sampling with comparator unpowered");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("new write taken before response");
  c_done: cover property (conv_done_irq);
  c_hold: cover property ($fell(ana_sample));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind sac_controller sac_controller_properties #(.FXP_DIV(FXP_DIV)) sac_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ana_sample(ana_sample), .cmp_power(cmp_power), .dac_code(dac_code),
  .conv_done_irq(conv_done_irq));
`default_nettype wire

//--- sac_afe_model.sv
`default_nettype none
module sac_afe_model (
  // clock
  input  wire logic        aclk,
  // analog levels of the four inputs
  input  wire logic [39:0] levels,
  // controller side
  input  wire logic [1:0]  ana_sel,
  input  wire logic        ana_sample,
  input  wire logic        cmp_power,
  input  wire logic [9:0]  dac_code,
  output var  logic        cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  logic [7:0] warm = 8'h00;
  logic       junk = 1'b0;
  always @(posedge aclk) begin
    junk <= ~junk;
    if (ana_sample) held <= levels[ana_sel * 10 +: 10];
    if (!cmp_power) warm <= 8'h00;
    else if (warm != 8'hFF) warm <= warm + 8'h01;
  end
  // an unsettled comparator answers garbage for 1 us after power-up
  always_comb begin
    if (warm < 8'h64) cmp_above = junk;
    else cmp_above = (held >= dac_code);
  end
endmodule
`default_nettype wire

//--- sac_controller_test.sv
`include "sac_regs.vh"
`default_nettype none
module sac_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 2;
  localparam int LIMIT = 40000;
  localparam logic [7:0] smp [8] = '{8'h0C, 8'h18, 8'h30, 8'h58,
                                     8'h18, 8'h30, 8'h60, 8'hB0};
  localparam logic [7:0] cnv [8] = '{8'h24, 8'h30, 8'h48, 8'h70,
                                     8'h48, 8'h60, 8'h90, 8'hE0};
  localparam logic [9:0] lvl [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2A6};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ana_sel;
  logic        cmp_above, ana_sample, cmp_power, conv_done_irq;
  logic [9:0]  dac_code;
  int          error_cnt = 0, checked = 0, cycles = 0;
  always #5 aclk = ~aclk;
  sac_controller #(.FXP_DIV(D)) sac_controller_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cmp_above(cmp_above), .ana_sel(ana_sel), .ana_sample(ana_sample),
    .cmp_power(cmp_power), .dac_code(dac_code),
    .conv_done_irq(conv_done_irq));
  sac_afe_model sac_afe_model_i (
    .aclk(aclk), .levels({lvl[3], lvl[2], lvl[1], lvl[0]}),
    .ana_sel(ana_sel), .ana_sample(ana_sample), .cmp_power(cmp_power),
    .dac_code(dac_code), .cmp_above(cmp_above));
  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("Error timeout expected %0d seen %0d", LIMIT, cycles);
      wrap_up;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bready is held from the start, so the response is taken at once
  task automatic wr(input logic [15:0] idx, input logic [7:0] dat,
                    output logic [1:0] resp);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] dat,
                    output logic [1:0] resp);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_irq(input int lim, output int cyc, output int hi);
    cyc = 0;
    hi = 0;
    do begin
      @(posedge aclk);
      cyc++;
      if (ana_sample === 1'b1) hi++;
    end while (conv_done_irq !== 1'b1 && cyc < lim);
  endtask
  // stop writes land in the comparison phase, never mid-sample
  task automatic wait_fall;
    do @(posedge aclk); while (ana_sample !== 1'b1);
    do @(posedge aclk); while (ana_sample !== 1'b0);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`SAC_IDX_MODE, d, r);
    chk("mode reset", 32'h0, d);
    rd(`SAC_IDX_CHAN, d, r);
    chk("chan reset", 32'h0, d);
    rd(16'h0010, d, r);
    chk("unmapped resp", 32'(`SAC_RESP_SLVERR), 32'(r));
    wr(16'h0010, 8'h01, r);
    chk("unmapped wr resp", 32'(`SAC_RESP_SLVERR), 32'(r));
    wr(`SAC_IDX_CHAN, 8'h03, r);
    chk("chan resp", 32'(`SAC_RESP_OKAY), 32'(r));
    rd(`SAC_IDX_CHAN, d, r);
    chk("chan byte", 32'h3, d);
    chk("idle power", 32'h0, 32'(cmp_power));
  endtask
  task automatic t_unsettled;
    int          c, h;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`SAC_IDX_MODE, 8'h80, r);
    repeat (2) @(posedge aclk);
    chk("converting power", 32'h1, 32'(cmp_power));
    wait_irq(1000, c, h);
    chk("first irq", 32'h1, 32'(c < 1000));
    rd(`SAC_IDX_STATUS, d, r);
    chk("unreliable flag", 32'h1, 32'(d[3]));
    wait_fall;
    wr(`SAC_IDX_MODE, 8'h00, r);
  endtask
  task automatic t_modes;
    logic [7:0]  f;
    int          c, h;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`SAC_IDX_MODE, 8'h01, r);
    repeat (110) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      f = 8'(i) << 3;
      wr(`SAC_IDX_CHAN, 8'(i % 4), r);
      wr(`SAC_IDX_MODE, 8'h01 | f, r);
      repeat (2) @(posedge aclk);
      wr(`SAC_IDX_MODE, 8'h81 | f, r);
      wait_irq(1000, c, h);
      chk("sample length", 32'h1,
          32'(h + 1 >= D * smp[i] && h <= D * smp[i] + 1));
      chk("conv length", 32'h1,
          32'(c + 4 >= D * cnv[i] && c <= D * cnv[i] + 3));
      chk("ana_sel", 32'(i % 4), 32'(ana_sel));
      rd(`SAC_IDX_RES_WORD, d, r);
      chk("result word", 32'(lvl[i % 4]), d);
      rd(`SAC_IDX_RES_HIGH, d, r);
      chk("result high", 32'(lvl[i % 4] >> 2), d);
      wait_irq(1000, c, h);
      chk("repeat", 32'h1, 32'(c <= D * cnv[i] + 3));
      wait_fall;
      wr(`SAC_IDX_MODE, 8'h01 | f, r);
    end
  endtask
  task automatic t_abort;
    int          c, h;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`SAC_IDX_MODE, 8'h01, r);
    wr(`SAC_IDX_CHAN, 8'h01, r);
    repeat (2) @(posedge aclk);
    wr(`SAC_IDX_MODE, 8'h81, r);
    wait_fall;
    repeat (3) @(posedge aclk);
    wr(`SAC_IDX_CHAN, 8'h01, r);
    wait_irq(1000, c, h);
    chk("restart length", 32'h1, 32'(c + 4 >= D * 36));
    rd(`SAC_IDX_RES_WORD, d, r);
    chk("restart result", 32'(lvl[1]), d);
    rd(`SAC_IDX_STATUS, d, r);
    chk("settled flag", 32'h0, 32'(d[3]));
    wait_fall;
    wr(`SAC_IDX_MODE, 8'h01, r);
    wait_irq(200, c, h);
    chk("stopped irq", 32'd200, 32'(c));
    chk("stopped sample", 32'h0, 32'(h));
    chk("waiting power", 32'h1, 32'(cmp_power));
    wr(`SAC_IDX_MODE, 8'h00, r);
    repeat (2) @(posedge aclk);
    chk("stopped power", 32'h0, 32'(cmp_power));
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_unsettled;
    t_modes;
    t_abort;
    wrap_up;
  end
endmodule
`default_nettype wire
